// file: rtl/tel_limit_cfg.sv
`timescale 1ns/10ps
// Behaviour
// RULE1: Status bit frozen in shutdown; interrupt-mode clear still clears it.
// RULE2: Enable resets to 0; writing 1 lets the event pin drive.
// RULE3: Enable, polarity, mode writes ignored while either lock is set.
// RULE4: Source select unchanged while window lock is set.
// RULE5: Event fields writable in shutdown; event pin frozen until shutdown ends.
// RULE6: Select 0 trips on all three limits; 1 on critical only.
// RULE7: Polarity 0 means active-low pin; 1 means active-high.
// RULE8: Mode 0 is comparator; 1 is latched interrupt.
// RULE9: Three 16-bit limit registers, 0.25 degree two's complement.
// RULE10: Enabled event output asserts when ambient leaves the limits.
// RULE11: Pointer 02h upper, 03h lower, 04h critical limit.
// RULE12: Limit bit 12 sign, 11..2 value; other bits read zero.
// RULE13: Locks block limit writes and stay set until reset.
// RULE14: Writing 1 to interrupt clear releases latch; reads return 0.
// RULE15: Shutdown halts conversions; registers stay readable and writable.
// RULE16: Ambient flags: 15 at/above critical, 14 above upper, 13 below lower.
// RULE17: Disabled output holds pin at inactive level for its polarity.
module tel_limit_cfg (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic        lk_req,
  input  wire logic        lk_wr,
  input  wire logic [7:0]  lk_ptr,
  input  wire logic [15:0] lk_wdata,
  output logic             lk_busy,
  output logic             lk_ack,
  output logic [15:0]      lk_rdata,
  input  wire logic [12:0] ambient_temperature,
  output logic             conv_halt,
  output logic             event_pin
);

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        ack_tgl;
    logic [15:0] rdata;
    logic [1:0]  hyst;
    logic        shutdown_control;
    logic        crit_lock;
    logic        win_lock;
    logic        stat;
    logic        en;
    logic        sel;
    logic        pol;
    logic        mode;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic        trig_d;
    logic        pin;
  } tel_core_t;

  tel_core_t   r;
  tel_core_t   n;
  logic        x_req_tgl;
  logic        x_wr;
  logic [7:0]  x_ptr;
  logic [15:0] x_wdata;
  logic        req_go;
  logic        wr_go;
  logic        cfg_wr;
  logic        locked;
  logic        int_clr;
  logic        f_crit;
  logic        f_up;
  logic        f_lo;
  logic        trig;
  logic        pin_act;
  logic [15:0] cfg_rd;
  logic [15:0] amb_rd;
  logic [15:0] rd_mux;
  logic [15:0] wlim;

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain request and answer holder
  tel_link u_link (
    .link_clk  (link_clk),
    .sys_rst   (sys_rst),
    .lk_req    (lk_req),
    .lk_wr     (lk_wr),
    .lk_ptr    (lk_ptr),
    .lk_wdata  (lk_wdata),
    .lk_busy   (lk_busy),
    .lk_ack    (lk_ack),
    .lk_rdata  (lk_rdata),
    .x_req_tgl (x_req_tgl),
    .x_wr      (x_wr),
    .x_ptr     (x_ptr),
    .x_wdata   (x_wdata),
    .x_ack_tgl (r.ack_tgl),
    .x_rdata   (r.rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request strobes from the synchronised toggle
  assign req_go  = r.req_s2 ^ r.req_s3;
  assign wr_go   = req_go & x_wr;
  assign cfg_wr  = wr_go && (x_ptr == tel_pkg::PTR_CONFIG);
  assign locked  = r.crit_lock | r.win_lock;
  assign int_clr = cfg_wr & x_wdata[tel_pkg::CFG_INT_CLR];
  assign wlim    = x_wdata & tel_pkg::LIM_MASK;  // RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Signed compares of ambient against the limits
  assign f_crit = $signed(ambient_temperature)
                  >= $signed(r.crit[tel_pkg::TEMP_MSB:0]);  // RULE16
  assign f_up   = $signed(ambient_temperature)
                  > $signed(r.upper[tel_pkg::TEMP_MSB:0]);  // RULE16
  assign f_lo   = $signed(ambient_temperature)
                  < $signed(r.lower[tel_pkg::TEMP_MSB:0]);  // RULE16

  // Trip condition by source select
  assign trig = r.en & (r.sel ? f_crit : (f_crit | f_up | f_lo));  // RULE6
  assign pin_act = r.en & r.stat;  // RULE17

  ////////////////////////////////////////////////////////////////////////////
  // Read words
  always_comb begin
    cfg_rd = 16'h0000;
    cfg_rd[tel_pkg::CFG_HYST_MSB:tel_pkg::CFG_HYST_LSB] = r.hyst;
    cfg_rd[tel_pkg::CFG_SHUTDOWN_CONTROL]      = r.shutdown_control;
    cfg_rd[tel_pkg::CFG_CRIT_LOCK] = r.crit_lock;
    cfg_rd[tel_pkg::CFG_WIN_LOCK]  = r.win_lock;
    cfg_rd[tel_pkg::CFG_INT_CLR]   = 1'b0;  // RULE14
    cfg_rd[tel_pkg::CFG_STAT]      = r.stat;
    cfg_rd[tel_pkg::CFG_EN]        = r.en;
    cfg_rd[tel_pkg::CFG_SEL]       = r.sel;
    cfg_rd[tel_pkg::CFG_POL]       = r.pol;
    cfg_rd[tel_pkg::CFG_MODE]      = r.mode;
    amb_rd = {3'h0, ambient_temperature};
    amb_rd[tel_pkg::AMB_CRIT_FLAG]  = f_crit;  // RULE16
    amb_rd[tel_pkg::AMB_UPPER_FLAG] = f_up;
    amb_rd[tel_pkg::AMB_LOWER_FLAG] = f_lo;
  end

  // Pointer decode for reads
  always_comb begin
    if (x_ptr == tel_pkg::PTR_CONFIG) begin
      rd_mux = cfg_rd;
    end else if (x_ptr == tel_pkg::PTR_UPPER) begin  // RULE11
      rd_mux = r.upper;
    end else if (x_ptr == tel_pkg::PTR_LOWER) begin  // RULE11
      rd_mux = r.lower;
    end else if (x_ptr == tel_pkg::PTR_CRIT) begin  // RULE11
      rd_mux = r.crit;
    end else if (x_ptr == tel_pkg::PTR_AMBIENT) begin
      rd_mux = amb_rd;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n        = r;
    n.req_s1 = x_req_tgl;
    n.req_s2 = r.req_s1;
    n.req_s3 = r.req_s2;
    n.trig_d = trig;
    // Answer every request with the word read before any write lands
    if (req_go) begin
      n.rdata   = rd_mux;
      n.ack_tgl = ~r.ack_tgl;
    end
    // Configuration write; all fields accepted in shutdown
    if (cfg_wr) begin  // RULE5
      if (!locked) begin  // RULE3
        n.hyst = x_wdata[tel_pkg::CFG_HYST_MSB:tel_pkg::CFG_HYST_LSB];
        n.en   = x_wdata[tel_pkg::CFG_EN];  // RULE2
        n.pol  = x_wdata[tel_pkg::CFG_POL];  // RULE7
        n.mode = x_wdata[tel_pkg::CFG_MODE];  // RULE8
        n.shutdown_control = x_wdata[tel_pkg::CFG_SHUTDOWN_CONTROL];
      end else if (!x_wdata[tel_pkg::CFG_SHUTDOWN_CONTROL]) begin
        n.shutdown_control = 1'b0;
      end
      if (!r.win_lock) begin  // RULE4
        n.sel = x_wdata[tel_pkg::CFG_SEL];
      end
      // Locks only set; reset is the sole way out
      n.crit_lock = r.crit_lock | x_wdata[tel_pkg::CFG_CRIT_LOCK];  // RULE13
      n.win_lock  = r.win_lock | x_wdata[tel_pkg::CFG_WIN_LOCK];  // RULE13
    end
    // Limit writes, gated by the locks
    if (wr_go && x_ptr == tel_pkg::PTR_UPPER && !r.win_lock) begin  // RULE13
      n.upper = wlim;  // RULE9
    end else if (wr_go && x_ptr == tel_pkg::PTR_LOWER && !r.win_lock) begin
      n.lower = wlim;  // RULE9
    end else if (wr_go && x_ptr == tel_pkg::PTR_CRIT && !r.crit_lock) begin
      n.crit = wlim;  // RULE9
    end
    // Status: comparator follows, interrupt latches on a new trip
    if (!r.shutdown_control) begin
      if (!r.mode) begin
        n.stat = trig;  // RULE10
      end else if (trig && !r.trig_d) begin
        n.stat = 1'b1;  // RULE8
      end else if (int_clr) begin
        n.stat = 1'b0;  // RULE14
      end
    end else if (r.mode && int_clr) begin
      n.stat = 1'b0;  // RULE1
    end
    // Pin holds its level through shutdown
    if (!r.shutdown_control) begin  // RULE5
      n.pin = r.pol ? pin_act : ~pin_act;  // RULE7
    end
    if (sys_rst) begin
      n           = '0;
      n.hyst      = tel_pkg::HYST_RESET;
      n.shutdown_control      = tel_pkg::FLD_RESET;
      n.crit_lock = tel_pkg::FLD_RESET;
      n.win_lock  = tel_pkg::FLD_RESET;
      n.stat      = tel_pkg::FLD_RESET;
      n.en        = tel_pkg::FLD_RESET;  // RULE2
      n.sel       = tel_pkg::FLD_RESET;  // RULE6
      n.pol       = tel_pkg::FLD_RESET;  // RULE7
      n.mode      = tel_pkg::FLD_RESET;  // RULE8
      n.upper     = tel_pkg::LIM_RESET;
      n.lower     = tel_pkg::LIM_RESET;
      n.crit      = tel_pkg::LIM_RESET;
      n.pin       = tel_pkg::PIN_RESET;  // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock) begin
    r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign conv_halt = r.shutdown_control;  // RULE15
  assign event_pin = r.pin;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  stat_frozen_a: assert property ( // RULE1
    (r.shutdown_control && !(r.mode && int_clr)) |=> $stable(r.stat))
    else $error("status moved during shutdown");

  shutdown_control_clear_a: assert property ( // RULE1
    (r.shutdown_control && r.mode && int_clr) |=> !r.stat)
    else $error("interrupt clear ignored in shutdown");

  reset_fields_a: assert property ( // RULE2
    @(posedge clock) disable iff (1'b0)
    sys_rst |=> (!r.en && !r.sel && !r.pol && !r.mode && event_pin))
    else $error("event fields wrong after reset");

  lock_fields_a: assert property ( // RULE3
    (cfg_wr && locked) |=> $stable({r.en, r.pol, r.mode}))
    else $error("locked event field changed");

  sel_lock_a: assert property ( // RULE4
    r.win_lock |=> $stable(r.sel))
    else $error("select changed under window lock");

  pin_hold_a: assert property ( // RULE5
    r.shutdown_control |=> $stable(event_pin))
    else $error("event pin moved in shutdown");

  crit_only_a: assert property ( // RULE6
    (!r.shutdown_control && !r.mode && r.en && r.sel && !f_crit) |=> !r.stat)
    else $error("non-critical trip with critical select");

  trip_assert_a: assert property ( // RULE10
    (!r.shutdown_control && !r.mode && r.en && !r.sel && f_up && !cfg_wr) ##1 !r.shutdown_control
      |=> (event_pin == $past(r.pol, 1)))
    else $error("event pin not asserted on trip");

  limit_bits_a: assert property ( // RULE12
    ((r.upper | r.lower | r.crit) & ~tel_pkg::LIM_MASK) == 16'h0000)
    else $error("unused limit bits set");

  crit_lock_a: assert property ( // RULE13
    r.crit_lock |=> (r.crit_lock && $stable(r.crit)))
    else $error("critical limit changed under lock");

  clr_reads_a: assert property ( // RULE14
    (req_go && x_ptr == tel_pkg::PTR_CONFIG) |=> !r.rdata[5])
    else $error("interrupt clear read back as one");

  idle_pin_a: assert property ( // RULE17
    (!r.en && !r.shutdown_control) |=> (event_pin == !$past(r.pol)))
    else $error("disabled pin not inactive");

  // Field writes land when no lock stands
  en_write_a: assert property ( // RULE2
    (cfg_wr && !locked) |=> (r.en == $past(x_wdata[tel_pkg::CFG_EN])))
    else $error("enable write not applied");

  sd_write_a: assert property ( // RULE5
    (cfg_wr && r.shutdown_control && !locked)
      |=> (r.mode == $past(x_wdata[tel_pkg::CFG_MODE])))
    else $error("event field write lost in shutdown");

  // Trip sources and latched behaviour
  all_src_a: assert property ( // RULE6
    (!r.shutdown_control && !r.mode && r.en && !r.sel && f_lo) |=> r.stat)
    else $error("lower trip missed with all limits selected");

  pol_level_a: assert property ( // RULE7
    (!r.shutdown_control && r.en && r.stat) |=> (event_pin == $past(r.pol)))
    else $error("asserted pin level wrong for polarity");

  latch_set_a: assert property ( // RULE8
    (!r.shutdown_control && r.mode && trig && !r.trig_d) |=> r.stat)
    else $error("interrupt not latched on new trip");

  latch_hold_a: assert property ( // RULE8
    (!r.shutdown_control && r.mode && r.stat && !int_clr) |=> r.stat)
    else $error("latched interrupt dropped without clear");

  int_clear_a: assert property ( // RULE14
    (!r.shutdown_control && r.mode && int_clr && !(trig && !r.trig_d)) |=> !r.stat)
    else $error("interrupt clear ignored");

  // Limit writes by pointer
  upper_write_a: assert property ( // RULE11
    (wr_go && x_ptr == tel_pkg::PTR_UPPER && !r.win_lock)
      |=> (r.upper == $past(x_wdata & tel_pkg::LIM_MASK)))
    else $error("upper limit write lost");

  lower_write_a: assert property ( // RULE11
    (wr_go && x_ptr == tel_pkg::PTR_LOWER && !r.win_lock)
      |=> (r.lower == $past(x_wdata & tel_pkg::LIM_MASK)))
    else $error("lower limit write lost");

  crit_write_a: assert property ( // RULE9
    (wr_go && x_ptr == tel_pkg::PTR_CRIT && !r.crit_lock)
      |=> (r.crit == $past(x_wdata & tel_pkg::LIM_MASK)))
    else $error("critical limit write lost");

  win_lock_a: assert property ( // RULE13
    r.win_lock |=> (r.win_lock && $stable(r.upper) && $stable(r.lower)))
    else $error("window limits changed under lock");

  halt_write_a: assert property ( // RULE15
    (cfg_wr && !locked)
      |=> (conv_halt == $past(x_wdata[tel_pkg::CFG_SHUTDOWN_CONTROL])))
    else $error("shutdown write not applied");

  latch_c:    cover property (r.mode && !r.shutdown_control && trig && !r.trig_d);
  sdclr_c:    cover property (r.shutdown_control && r.mode && int_clr && r.stat);
  lockwr_c:   cover property (cfg_wr && locked);
  sdwr_c:     cover property (cfg_wr && r.shutdown_control);
  crit_sel_c: cover property (r.en && r.sel && f_crit && !r.shutdown_control);

endmodule : tel_limit_cfg

// file: rtl/tel_link.sv
`timescale 1ns/10ps
// Link-side half of the register crossing, clocked by the serial engine
module tel_link (
  input  wire logic        link_clk,
  input  wire logic        sys_rst,
  input  wire logic        lk_req,
  input  wire logic        lk_wr,
  input  wire logic [7:0]  lk_ptr,
  input  wire logic [15:0] lk_wdata,
  output logic             lk_busy,
  output logic             lk_ack,
  output logic [15:0]      lk_rdata,
  output logic             x_req_tgl,
  output logic             x_wr,
  output logic [7:0]       x_ptr,
  output logic [15:0]      x_wdata,
  input  wire logic        x_ack_tgl,
  input  wire logic [15:0] x_rdata
);

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        req_tgl;
    logic        wr;
    logic [7:0]  ptr;
    logic [15:0] wdata;
    logic        busy;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    logic        ack;
    logic [15:0] rdata;
  } tel_link_t;

  tel_link_t r;
  tel_link_t n;
  logic      ack_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: reset sync, request capture, answer pickup
  always_comb begin
    n        = r;
    ack_edge = r.ack_s2 ^ r.ack_s3;
    n.rst_s1 = sys_rst;
    n.rst_s2 = r.rst_s1;
    n.ack_s1 = x_ack_tgl;
    n.ack_s2 = r.ack_s1;
    n.ack_s3 = r.ack_s2;
    n.ack    = 1'b0;
    if (r.rst_s2) begin
      n.req_tgl = 1'b0;
      n.wr      = 1'b0;
      n.ptr     = 8'h00;
      n.wdata   = 16'h0000;
      n.busy    = 1'b0;
      n.ack_s1  = 1'b0;
      n.ack_s2  = 1'b0;
      n.ack_s3  = 1'b0;
      n.rdata   = 16'h0000;
    end else if (r.busy) begin
      // Words held still until the core answers
      if (ack_edge) begin
        n.busy  = 1'b0;
        n.ack   = 1'b1;
        n.rdata = x_rdata;
      end
    end else if (lk_req) begin
      n.req_tgl = ~r.req_tgl;
      n.wr      = lk_wr;
      n.ptr     = lk_ptr;
      n.wdata   = lk_wdata;
      n.busy    = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge link_clk) begin
    r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign lk_busy   = r.busy;
  assign lk_ack    = r.ack;
  assign lk_rdata  = r.rdata;
  assign x_req_tgl = r.req_tgl;
  assign x_wr      = r.wr;
  assign x_ptr     = r.ptr;
  assign x_wdata   = r.wdata;

endmodule : tel_link

// file: rtl/tel_pkg.sv
package tel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register pointers
  localparam logic [7:0] PTR_CONFIG  = 8'h01;
  localparam logic [7:0] PTR_UPPER   = 8'h02;
  localparam logic [7:0] PTR_LOWER   = 8'h03;
  localparam logic [7:0] PTR_CRIT    = 8'h04;
  localparam logic [7:0] PTR_AMBIENT = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register field positions
  localparam int CFG_HYST_LSB  = 9;
  localparam int CFG_HYST_MSB  = 10;
  localparam int CFG_SHUTDOWN_CONTROL      = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_WIN_LOCK  = 6;
  localparam int CFG_INT_CLR   = 5;
  localparam int CFG_STAT      = 4;
  localparam int CFG_EN        = 3;
  localparam int CFG_SEL       = 2;
  localparam int CFG_POL       = 1;
  localparam int CFG_MODE      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Ambient register flag positions and limit layout
  localparam int AMB_CRIT_FLAG  = 15;
  localparam int AMB_UPPER_FLAG = 14;
  localparam int AMB_LOWER_FLAG = 13;
  localparam int TEMP_MSB       = 12;
  localparam logic [15:0] LIM_MASK = 16'h1ffc;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] LIM_RESET  = 16'h0000;
  localparam logic [1:0]  HYST_RESET = 2'h0;
  localparam logic        FLD_RESET  = 1'h0;
  localparam logic        PIN_RESET  = 1'h1;

endpackage : tel_pkg

// file: tb/tel_host_model.sv
`timescale 1ns/10ps
// Host controller model driving the link request group
module tel_host_model (
  input  wire logic        link_clk,
  input  wire logic        lk_busy,
  input  wire logic        lk_ack,
  input  wire logic [15:0] lk_rdata,
  output logic             lk_req,
  output logic             lk_wr,
  output logic [7:0]       lk_ptr,
  output logic [15:0]      lk_wdata
);
  logic timed_out;

  // Idle request lines at time zero
  initial begin
    lk_req    = 1'b0;
    lk_wr     = 1'b0;
    lk_ptr    = 8'h00;
    lk_wdata  = 16'h0000;
    timed_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access: request held to the taking edge, answer taken at ack edge
  task automatic access(input logic wr, input logic [7:0] ptr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
    int n;
    n = 0;
    while (lk_busy !== 1'b0) @(posedge link_clk);
    @(posedge link_clk);
    #2;
    lk_req   = 1'b1;
    lk_wr    = wr;
    lk_ptr   = ptr;
    lk_wdata = wdata;
    @(posedge link_clk);
    #2;
    // Released lines carry the inverse so stale values never pass
    lk_req   = 1'b0;
    lk_wr    = ~wr;
    lk_ptr   = ~ptr;
    lk_wdata = ~wdata;
    do begin
      @(posedge link_clk);
      n++;
    end while (lk_ack !== 1'b1 && n < 20);
    if (n >= 20) timed_out = 1'b1;
    rdata = lk_rdata;
  endtask : access

endmodule : tel_host_model

// file: tb/test_tel_limit_cfg.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
// Register and event checks of the limit and configuration block
module test_tel_limit_cfg;
  logic        clock;
  logic        link_clk;
  logic        sys_rst;
  logic        lk_req;
  logic        lk_wr;
  logic [7:0]  lk_ptr;
  logic [15:0] lk_wdata;
  logic        lk_busy;
  logic        lk_ack;
  logic [15:0] lk_rdata;
  logic [12:0] ambient_temperature;
  logic        conv_halt;
  logic        event_pin;
  logic [15:0] r;
  logic [7:0]  lp [3];
  logic [15:0] lv [3];
  int          errors;
  int          n_checks;

  tel_limit_cfg tel_limit_cfg_inst (
    .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
    .lk_req(lk_req), .lk_wr(lk_wr), .lk_ptr(lk_ptr),
    .lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_ack(lk_ack),
    .lk_rdata(lk_rdata), .ambient_temperature(ambient_temperature),
    .conv_halt(conv_halt), .event_pin(event_pin)
  );

  tel_host_model tel_host_model_inst (
    .link_clk(link_clk), .lk_busy(lk_busy), .lk_ack(lk_ack),
    .lk_rdata(lk_rdata), .lk_req(lk_req), .lk_wr(lk_wr),
    .lk_ptr(lk_ptr), .lk_wdata(lk_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core clock and an unrelated link clock
  initial clock = 1'b0;
  always #10 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access helpers
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [15:0] x;
    tel_host_model_inst.access(1'b1, p, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    tel_host_model_inst.access(1'b0, p, 16'h0000, d);
  endtask : rd

  task automatic amb(input logic [12:0] t);
    @(posedge clock);
    #2;
    ambient_temperature = t;
    repeat (8) @(posedge clock);
    #2;
  endtask : amb

  task automatic settle;
    repeat (8) @(posedge clock);
    #2;
  endtask : settle

  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    ambient_temperature = 13'h0280;
    lp = '{tel_pkg::PTR_UPPER, tel_pkg::PTR_LOWER, tel_pkg::PTR_CRIT};
    lv = '{16'h0190, 16'h0050, 16'h0280};
    repeat (12) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    repeat (6) @(posedge link_clk);
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("cfg reset", 16'h0000, r)
    `CHK("pin reset", 1'b1, event_pin)
    `CHK("halt reset", 1'b0, conv_halt)
    // Limit registers keep only sign and value bits
    for (int i = 0; i < 3; i++) begin
      wr(lp[i], 16'hffff);
      rd(lp[i], r);
      `CHK("limit mask", 16'h1ffc, r)
      wr(lp[i], lv[i]);
      rd(lp[i], r);
      `CHK("limit value", lv[i], r)
    end
    rd(8'h06, r);
    `CHK("unmapped", 16'h0000, r)
    // Ambient flags against the three limits
    amb(13'h0200);
    rd(tel_pkg::PTR_AMBIENT, r);
    `CHK("amb above", 16'h4200, r)
    amb(13'h0040);
    rd(tel_pkg::PTR_AMBIENT, r);
    `CHK("amb below", 16'h2040, r)
    amb(13'h0280);
    rd(tel_pkg::PTR_AMBIENT, r);
    `CHK("amb crit", 16'hc280, r)
    `CHK("pin disabled", 1'b1, event_pin)
    // Comparator, active low then active high, all limits
    wr(tel_pkg::PTR_CONFIG, 16'h0008);
    settle();
    `CHK("pin cmp crit", 1'b0, event_pin)
    amb(13'h0100);
    `CHK("pin in window", 1'b1, event_pin)
    amb(13'h0040);
    `CHK("pin low trip", 1'b0, event_pin)
    wr(tel_pkg::PTR_CONFIG, 16'h000a);
    settle();
    `CHK("pin active high", 1'b1, event_pin)
    // Critical-only source select
    wr(tel_pkg::PTR_CONFIG, 16'h000e);
    settle();
    `CHK("sel ignores low", 1'b0, event_pin)
    amb(13'h0200);
    `CHK("sel ignores up", 1'b0, event_pin)
    amb(13'h0280);
    `CHK("sel crit", 1'b1, event_pin)
    // Latched interrupt and its clear
    amb(13'h0100);
    wr(tel_pkg::PTR_CONFIG, 16'h0009);
    amb(13'h0200);
    `CHK("int set", 1'b0, event_pin)
    amb(13'h0100);
    `CHK("int latched", 1'b0, event_pin)
    wr(tel_pkg::PTR_CONFIG, 16'h0029);
    settle();
    `CHK("int cleared", 1'b1, event_pin)
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("clear reads 0", 16'h0009, r)
    amb(13'h0200);
    // Shutdown freezes pin and status, clear still works
    wr(tel_pkg::PTR_CONFIG, 16'h0109);
    amb(13'h0100);
    `CHK("halt set", 1'b1, conv_halt)
    wr(tel_pkg::PTR_CONFIG, 16'h0129);
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("sd int clear", 16'h0109, r)
    amb(13'h0200);
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("sd stat frozen", 16'h0109, r)
    wr(tel_pkg::PTR_CONFIG, 16'h010b);
    settle();
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("sd write", 16'h010b, r)
    `CHK("sd pin frozen", 1'b0, event_pin)
    wr(tel_pkg::PTR_CONFIG, 16'h0008);
    amb(13'h0100);
    `CHK("halt clear", 1'b0, conv_halt)
    `CHK("pin after sd", 1'b1, event_pin)
    // Locks block fields and limits and stay set
    wr(tel_pkg::PTR_CONFIG, 16'h0048);
    wr(tel_pkg::PTR_CONFIG, 16'h0007);
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("win lock cfg", 16'h0048, r & 16'hffef)
    wr(tel_pkg::PTR_UPPER, 16'h0000);
    rd(tel_pkg::PTR_UPPER, r);
    `CHK("upper locked", 16'h0190, r)
    wr(tel_pkg::PTR_CONFIG, 16'h00c8);
    wr(tel_pkg::PTR_CRIT, 16'h0000);
    rd(tel_pkg::PTR_CRIT, r);
    `CHK("crit locked", 16'h0280, r)
    wr(tel_pkg::PTR_CONFIG, 16'h0000);
    rd(tel_pkg::PTR_CONFIG, r);
    `CHK("locks held", 16'h00c8, r & 16'hffef)
    `CHK("host answer", 1'b0, tel_host_model_inst.timed_out)
    give_verdict();
  end

endmodule : test_tel_limit_cfg
